// >>> test_tsc_status_regs.sv
/*
  Self-checking bench for the tile status configuration bank.
  Assumes the bank alone, driven at falling edges, clock enable held high except for one frozen write.
*/
`timescale 1ns/10ps
module test_tsc_status_regs;
  import tsc_pkg::*;
  logic clock, reset_n, clock_en, ps_write, ps_read, ps_rvalid, event_take, event_target_valid;
  logic [15:0] ps_resource_id, event_vector;
  logic [31:0] ps_wdata, ps_rdata, event_target, otp_security_word, seed, v, w;
  logic [7:0] processor_number;
  logic [1:0] pll_mode_pin_value;
  logic [3:0] osc_edge, otp_sector_lock;
  logic second_core_powered_off, otp_poll_disable, boot_from_ram, boot_from_jtag;
  logic otp_security_load, all_threads_paused, rgmii_enable, rgmii_tx_clk, rgmii_tx_launch;
  logic low_power_divide, usb_utmi_select, ulpi_enable, global_debug_disable, jtag_tap_disable;
  logic otp_master_lock, otp_redundancy_enable, secure_boot_override, jtag_config_disable;
  int err_total, n_compared, cyc, n, m;

  tsc_status_regs DUT (.clock(clock), .reset_n(reset_n), .clock_en(clock_en),
    .ps_write(ps_write), .ps_read(ps_read), .ps_resource_id(ps_resource_id),
    .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .ps_rvalid(ps_rvalid), .event_take(event_take),
    .event_vector(event_vector), .event_target(event_target),
    .event_target_valid(event_target_valid), .processor_number(processor_number),
    .second_core_powered_off(second_core_powered_off), .otp_poll_disable(otp_poll_disable),
    .boot_from_ram(boot_from_ram), .boot_from_jtag(boot_from_jtag),
    .pll_mode_pin_value(pll_mode_pin_value), .otp_security_load(otp_security_load),
    .otp_security_word(otp_security_word), .all_threads_paused(all_threads_paused),
    .osc_edge(osc_edge), .rgmii_enable(rgmii_enable), .rgmii_tx_clk(rgmii_tx_clk),
    .rgmii_tx_launch(rgmii_tx_launch), .low_power_divide(low_power_divide),
    .usb_utmi_select(usb_utmi_select), .ulpi_enable(ulpi_enable),
    .global_debug_disable(global_debug_disable), .jtag_tap_disable(jtag_tap_disable),
    .otp_master_lock(otp_master_lock), .otp_sector_lock(otp_sector_lock),
    .otp_redundancy_enable(otp_redundancy_enable), .secure_boot_override(secure_boot_override),
    .jtag_config_disable(jtag_config_disable));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] exp_tile(input logic [31:0] x);
    return {6'h00, x[25:8], 2'h0, x[5:4], 1'b0, x[2:1], 1'b0};
  endfunction : exp_tile

  function automatic logic [31:0] exp_sec(input logic [31:0] x);
    return {x[31], 16'h0000, x[14], 1'b0, x[12:7], 1'b0, x[5:4], 3'h0, x[0]};
  endfunction : exp_sec

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] num, input logic [31:0] d);
    @(negedge clock);
    ps_write = 1'b1;
    ps_resource_id = {num, TSC_RES_TYPE};
    ps_wdata = d;
    @(negedge clock);
    ps_write = 1'b0;
  endtask : wr

  // answer is registered on the taking edge itself, so no wait loop is needed
  task automatic rd(input logic [15:0] id, input logic [31:0] exp, input logic [31:0] mask);
    @(negedge clock);
    ps_read = 1'b1;
    ps_resource_id = id;
    @(negedge clock);
    ps_read = 1'b0;
    chk("read valid", {31'h0, ps_rvalid}, 32'h1);
    chk("read data", ps_rdata & mask, exp);
  endtask : rd

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge clock);
      cyc++;
      if (cyc == 20000) begin
        err_total++;
        test_done();
      end
    end
  end

  initial begin
    seed = 32'hA516; reset_n = 1'b0; clock_en = 1'b1; ps_write = 1'b0; ps_read = 1'b0;
    ps_resource_id = 16'h0000; ps_wdata = 32'h0; event_take = 1'b0; event_vector = 16'h0;
    processor_number = 8'h00; second_core_powered_off = 1'b0; otp_poll_disable = 1'b0;
    boot_from_ram = 1'b0; boot_from_jtag = 1'b0; pll_mode_pin_value = 2'h0;
    otp_security_load = 1'b0; otp_security_word = 32'h0; all_threads_paused = 1'b0;
    osc_edge = 4'h0; err_total = 0; n_compared = 0;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    foreach (v[i]) if (i < 7 && i != 0 && i != 4) rd({i[7:0], 8'h0B}, 32'h0, 32'hFFFFFFFF);
    rd(16'h040B, 32'h0, 32'hFFFFFFFF);
    rd(16'h020C, 32'h0, 32'hFFFFFFFF);
    $display("test reset_values done");
    for (int k = 0; k < 5; k++) begin
      v = (k == 0) ? 32'hFFFFFFFF : rnd();
      // one pass forces dynamic mode while threads still run
      if (k == 1) v = (v | 32'h00000030) & 32'hBFFFFFFF;
      wr(8'h01, v);
      event_take = 1'b1;
      event_vector = v[15:0] ^ 16'hA5C3;
      @(negedge clock);
      event_take = 1'b0;
      @(negedge clock);
      chk("event target", event_target, {v[31:18], 2'b00, v[15:0] ^ 16'hA5C3});
      rd(16'h010B, {v[31:18], 18'h0}, 32'hFFFFFFFF);
      wr(8'h02, v);
      rd(16'h020B, exp_tile(v), 32'hFFFFFFFF);
      chk("tile pins", {29'h0, rgmii_enable, usb_utmi_select, ulpi_enable}, {29'h0, v[8], v[2:1]});
      all_threads_paused = v[30];
      repeat (2) @(negedge clock);
      chk("low power", {31'h0, low_power_divide}, {31'h0, v[4] & (~v[5] | v[30])});
    end
    $display("test vector_tile done");
    // disabling first restarts the divider count from zero
    wr(8'h02, 32'h0);
    for (int d = 1; d < 8; d += 3) begin
      wr(8'h02, (d << 9) | 32'h100);
      n = 0;
      while (rgmii_tx_clk !== 1'b0 && n < 40) begin @(negedge clock); n++; end
      while (rgmii_tx_clk !== 1'b1 && n < 40) begin @(negedge clock); n++; end
      n = 0;
      m = 0;
      while (rgmii_tx_clk === 1'b1 && n < 40) begin
        @(negedge clock);
        n++;
        m += rgmii_tx_launch;
      end
      while (rgmii_tx_clk !== 1'b1 && n < 40) begin
        @(negedge clock);
        n++;
        m += rgmii_tx_launch;
      end
      chk("rgmii period", n, d + 1);
      chk("rgmii launch", m, 1);
    end
    $display("test rgmii_clock done");
    for (int k = 0; k < 3; k++) begin
      v = rnd();
      {processor_number, second_core_powered_off, otp_poll_disable} = v[9:0];
      {boot_from_ram, boot_from_jtag, pll_mode_pin_value} = v[13:10];
      wr(8'h03, ~v);
      repeat (2) @(negedge clock);
      rd(16'h030B, {8'h00, v[9:2], 10'h0, v[1:0], v[13:10]}, 32'hFFFFFEFF);
    end
    $display("test boot_status done");
    w = rnd() & 32'h7FFFFFFF;
    @(negedge clock);
    otp_security_load = 1'b1;
    otp_security_word = w;
    @(negedge clock);
    otp_security_load = 1'b0;
    rd(16'h050B, exp_sec(w), 32'hFFFFFFFF);
    chk("sec pins", {global_debug_disable, jtag_tap_disable, otp_sector_lock}, {w[14], w[0], w[11:8]});
    v = rnd() | 32'h80000000;
    wr(8'h05, v);
    wr(8'h05, ~v);
    rd(16'h050B, exp_sec(v), 32'hFFFFFFFF);
    reset_n = 1'b0;
    @(negedge clock);
    reset_n = 1'b1;
    rd(16'h050B, 32'h0, 32'hFFFFFFFF);
    $display("test security done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h06, rnd() & 32'hFFFFFFFC | k);
      osc_edge = 4'(rnd());
      rd(16'h060B, k, 32'hFFFFFFFF);
    end
    wr(8'h06, 32'h0);
    osc_edge = 4'h0;
    // a write while the clock enable is low must leave the bank frozen
    clock_en = 1'b0;
    wr(8'h06, 32'h3);
    clock_en = 1'b1;
    rd(16'h060B, 32'h0, 32'hFFFFFFFF);
    repeat (10) @(negedge clock);
    for (int k = 7; k < 11; k++) rd({k[7:0], 8'h0B}, 32'h0, 32'hFFFF0000);
    $display("test oscillators done");
    test_done();
  end
endmodule : test_tsc_status_regs

// >>> tsc_ctrl_if.sv
/*
  Control and status wires between the register bank and its helpers.
  Assumes all parties share the core clock.
*/
`timescale 1ns/10ps
interface tsc_ctrl_if;
  logic [8:0]  rgmii_divider;
  logic [7:0]  rgmii_delay;
  logic        rgmii_enable;
  logic        rgmii_clk;
  logic        rgmii_launch;
  logic [3:0]  osc_run;
  logic [63:0] osc_counts;

  modport bank (output rgmii_divider, output rgmii_delay, output rgmii_enable,
                output osc_run, input rgmii_clk, input rgmii_launch, input osc_counts);
  modport rgmii (input rgmii_divider, input rgmii_delay, input rgmii_enable,
                 output rgmii_clk, output rgmii_launch);
  modport osc (input osc_run, output osc_counts);
endinterface : tsc_ctrl_if

// >>> tsc_osc_counters.sv
/*
  Four oscillator counters, each advanced by its own oscillator edge strobe.
  Assumes the strobes arrive already aligned to the core clock. Counts are
  deliberately kept through reset.
*/
`timescale 1ns/10ps
module tsc_osc_counters #(
  parameter int NUM   = 4,
  parameter int WIDTH = 16
) (
  // clock
  input wire logic            clock,
  input wire logic            clock_en,
  // oscillator edges
  input wire logic [NUM-1:0]  osc_edge,
  // control
  tsc_ctrl_if.osc             ctl
);
  import tsc_pkg::*;

  typedef struct packed {
    logic [NUM-1:0][WIDTH-1:0] count;
  } tsc_osc_state_t;

  tsc_osc_state_t st_reg;
  tsc_osc_state_t st_next;

  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < NUM; i++) begin
      if (ctl.osc_run[i] && osc_edge[i]) begin
        st_next.count[i] = st_reg.count[i] + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // no reset: the count survives a system reset
  always_ff @(posedge clock) begin
    if (clock_en) begin
      st_reg <= st_next;
    end
  end

  assign ctl.osc_counts = st_reg.count;
endmodule : tsc_osc_counters

// >>> tsc_pkg.sv
/*
  Shared constants for the tile status configuration bank.
  Assumes a single core clock; register numbers follow the processor-status
  resource numbering.
*/
package tsc_pkg;
  // resource identifier = register number shifted left 8, ored with the type
  localparam logic [7:0]  TSC_RES_TYPE     = 8'h0B;
  localparam int          TSC_RES_NUM_LSB  = 8;
  localparam logic [7:0]  TSC_REG_VECTOR   = 8'h01;
  localparam logic [7:0]  TSC_REG_TILECTL  = 8'h02;
  localparam logic [7:0]  TSC_REG_BOOT     = 8'h03;
  localparam logic [7:0]  TSC_REG_SECURITY = 8'h05;
  localparam logic [7:0]  TSC_REG_OSCCTL   = 8'h06;
  localparam logic [7:0]  TSC_REG_OSCDATA0 = 8'h07;
  localparam int          TSC_OSC_NUM      = 4;
  localparam int          TSC_OSC_WIDTH    = 16;

  // writable masks, everything else reads zero
  localparam logic [31:0] TSC_VECTOR_MASK  = 32'hFFFC0000;
  localparam logic [31:0] TSC_TILECTL_MASK = 32'h03FFFF36;
  localparam logic [31:0] TSC_SECURE_MASK  = 32'h80005FB1;
  localparam logic [31:0] TSC_OSCCTL_MASK  = 32'h00000003;
  localparam logic [31:0] TSC_ZERO         = 32'h00000000;

  // field positions
  localparam int TSC_VEC_HI_LSB   = 16;
  localparam int TSC_RG_DLY_LSB   = 18;
  localparam int TSC_RG_DIV_LSB   = 9;
  localparam int TSC_RG_EN_BIT    = 8;
  localparam int TSC_DIV_DYN_BIT  = 5;
  localparam int TSC_DIV_EN_BIT   = 4;
  localparam int TSC_USB_MODE_BIT = 2;
  localparam int TSC_ULPI_EN_BIT  = 1;
  localparam int TSC_BOOT_PROC_LSB = 16;
  localparam int TSC_BOOT_C1_BIT  = 5;
  localparam int TSC_BOOT_NOPOLL_BIT = 4;
  localparam int TSC_BOOT_RAM_BIT = 3;
  localparam int TSC_BOOT_JTAG_BIT = 2;
  localparam int TSC_SEC_WDIS_BIT = 31;
  localparam int TSC_SEC_GDBG_BIT = 14;
  localparam int TSC_SEC_MLOCK_BIT = 12;
  localparam int TSC_SEC_SLOCK_LSB = 8;
  localparam int TSC_SEC_REDUN_BIT = 7;
  localparam int TSC_SEC_SBOOT_BIT = 5;
  localparam int TSC_SEC_PLLJ_BIT = 4;
  localparam int TSC_SEC_JTAG_BIT = 0;
  localparam int TSC_OSC_CORE_BIT = 1;
  localparam int TSC_OSC_PERI_BIT = 0;

  localparam logic [8:0] TSC_DIV_ZERO = 9'h000;
  localparam logic [7:0] TSC_DLY_ZERO = 8'h00;
endpackage : tsc_pkg

// >>> tsc_rgmii_clkgen.sv
/*
  RGMII transmit clock divider and data launch delay.
  Assumes the core clock stands in for the PLL output.
*/
`timescale 1ns/10ps
module tsc_rgmii_clkgen (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // control
  tsc_ctrl_if.rgmii ctl
);
  import tsc_pkg::*;

  typedef struct packed {
    logic [8:0] count;
    logic       clk;
    logic [7:0] delay_left;
    logic       delay_run;
    logic       launch;
  } tsc_rg_state_t;

  tsc_rg_state_t st_reg;
  tsc_rg_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.launch = 1'b0;
    if (!ctl.rgmii_enable) begin
      st_next.count = TSC_DIV_ZERO;
      st_next.clk = 1'b0;
      st_next.delay_run = 1'b0;
    end else begin
      if (st_reg.count == ctl.rgmii_divider) begin
        st_next.count = TSC_DIV_ZERO;
        st_next.clk = 1'b1;
        st_next.delay_left = ctl.rgmii_delay;
        st_next.delay_run = 1'b1;
      end else begin
        st_next.count = st_reg.count + 9'h001;
      end
      if (st_reg.count == (ctl.rgmii_divider >> 1)) begin
        st_next.clk = 1'b0;
      end
      // data launches a programmable number of cycles after the rising edge
      if (st_reg.delay_run && st_reg.count != ctl.rgmii_divider) begin
        if (st_reg.delay_left == TSC_DLY_ZERO) begin
          st_next.launch = 1'b1;
          st_next.delay_run = 1'b0;
        end else begin
          st_next.delay_left = st_reg.delay_left - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else if (clock_en) begin
      st_reg <= st_next;
    end
  end

  assign ctl.rgmii_clk = st_reg.clk;
  assign ctl.rgmii_launch = st_reg.launch;
endmodule : tsc_rgmii_clkgen

// >>> tsc_status_regs.sv
/*
  Processor-status configuration bank for one tile: vector base, tile
  control, boot status, security word, oscillator control and counters.
  Assumes the processor issues one read or write per cycle on the status
  port, all inputs synchronous to clock; oscillator edges are pre-aligned.
*/
`timescale 1ns/10ps
module tsc_status_regs #(
  parameter int OSC_NUM   = tsc_pkg::TSC_OSC_NUM,
  parameter int OSC_WIDTH = tsc_pkg::TSC_OSC_WIDTH
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          reset_n,
  input  wire logic          clock_en,
  // processor-status access
  input  wire logic          ps_write,
  input  wire logic          ps_read,
  input  wire logic [15:0]   ps_resource_id,
  input  wire logic [31:0]   ps_wdata,
  output logic      [31:0]   ps_rdata,
  output logic               ps_rvalid,
  // event vectoring
  input  wire logic          event_take,
  input  wire logic [15:0]   event_vector,
  output logic      [31:0]   event_target,
  output logic               event_target_valid,
  // boot status sources
  input  wire logic [7:0]    processor_number,
  input  wire logic          second_core_powered_off,
  input  wire logic          otp_poll_disable,
  input  wire logic          boot_from_ram,
  input  wire logic          boot_from_jtag,
  input  wire logic [1:0]    pll_mode_pin_value,
  // security word from programmable memory
  input  wire logic          otp_security_load,
  input  wire logic [31:0]   otp_security_word,
  // thread activity
  input  wire logic          all_threads_paused,
  // oscillator edges
  input  wire logic [3:0]    osc_edge,
  // tile feature controls
  output logic               rgmii_enable,
  output logic               rgmii_tx_clk,
  output logic               rgmii_tx_launch,
  output logic               low_power_divide,
  output logic               usb_utmi_select,
  output logic               ulpi_enable,
  // security controls
  output logic               global_debug_disable,
  output logic               jtag_tap_disable,
  output logic               otp_master_lock,
  output logic      [3:0]    otp_sector_lock,
  output logic               otp_redundancy_enable,
  output logic               secure_boot_override,
  output logic               jtag_config_disable
);
  import tsc_pkg::*;

  generate
    if (OSC_NUM != TSC_OSC_NUM || OSC_WIDTH != TSC_OSC_WIDTH) begin : g_bad
      $error("oscillator bank must be four counters of sixteen bits");
    end
  endgenerate

  typedef struct packed {
    logic [31:0] vector;
    logic [31:0] tilectl;
    logic [31:0] boot;
    logic [31:0] secure;
    logic [31:0] oscctl;
    logic [31:0] rdata;
    logic        rvalid;
    logic [31:0] target;
    logic        target_valid;
    logic        lp_divide;
    logic        rg_clk;
    logic        rg_launch;
  } tsc_bank_state_t;

  tsc_bank_state_t st_reg;
  tsc_bank_state_t st_next;

  tsc_ctrl_if ctl ();

  // matches a processor-status resource id against a register number
  function automatic logic tsc_hit(input logic [15:0] rid, input logic [7:0] num);
    tsc_hit = (rid[7:0] == TSC_RES_TYPE) &&
              (rid[TSC_RES_NUM_LSB +: 8] == num);
  endfunction : tsc_hit

  // read data for a resource id; unmapped ids read zero
  function automatic logic [31:0] tsc_read(input logic [15:0] rid,
                                           input tsc_bank_state_t s,
                                           input logic [63:0] counts);
    logic [31:0] r;
    r = TSC_ZERO;
    if (tsc_hit(rid, TSC_REG_VECTOR)) begin
      r = s.vector & TSC_VECTOR_MASK;
    end
    if (tsc_hit(rid, TSC_REG_TILECTL)) begin
      r = s.tilectl & TSC_TILECTL_MASK;
    end
    if (tsc_hit(rid, TSC_REG_BOOT)) begin
      r = s.boot;
    end
    if (tsc_hit(rid, TSC_REG_SECURITY)) begin
      r = s.secure & TSC_SECURE_MASK;
    end
    if (tsc_hit(rid, TSC_REG_OSCCTL)) begin
      r = s.oscctl & TSC_OSCCTL_MASK;
    end
    for (int i = 0; i < TSC_OSC_NUM; i++) begin
      if (tsc_hit(rid, TSC_REG_OSCDATA0 + 8'(i))) begin
        r = {16'h0000, counts[i*TSC_OSC_WIDTH +: TSC_OSC_WIDTH]};
      end
    end
    tsc_read = r;
  endfunction : tsc_read

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.target_valid = 1'b0;

    // boot status follows its sources; it has no write path
    st_next.boot = TSC_ZERO;
    st_next.boot[TSC_BOOT_PROC_LSB +: 8] = processor_number;
    st_next.boot[TSC_BOOT_C1_BIT] = second_core_powered_off;
    st_next.boot[TSC_BOOT_NOPOLL_BIT] = otp_poll_disable;
    st_next.boot[TSC_BOOT_RAM_BIT] = boot_from_ram;
    st_next.boot[TSC_BOOT_JTAG_BIT] = boot_from_jtag;
    st_next.boot[1:0] = pll_mode_pin_value;

    if (ps_write) begin
      if (tsc_hit(ps_resource_id, TSC_REG_VECTOR)) begin
        st_next.vector = ps_wdata & TSC_VECTOR_MASK;
      end
      if (tsc_hit(ps_resource_id, TSC_REG_TILECTL)) begin
        st_next.tilectl = ps_wdata & TSC_TILECTL_MASK;
      end
      // once locked, the word only changes through reset or a memory reload
      if (tsc_hit(ps_resource_id, TSC_REG_SECURITY) &&
          !st_reg.secure[TSC_SEC_WDIS_BIT]) begin
        st_next.secure = ps_wdata & TSC_SECURE_MASK;
      end
      if (tsc_hit(ps_resource_id, TSC_REG_OSCCTL)) begin
        st_next.oscctl = ps_wdata & TSC_OSCCTL_MASK;
      end
    end

    // the hardware copy from programmable memory wins over a same-cycle write
    if (otp_security_load) begin
      st_next.secure = otp_security_word & TSC_SECURE_MASK;
    end

    if (ps_read) begin
      st_next.rdata = tsc_read(ps_resource_id, st_reg, ctl.osc_counts);
      st_next.rvalid = 1'b1;
    end

    if (event_take) begin
      st_next.target = {st_reg.vector[31:TSC_VEC_HI_LSB], event_vector};
      st_next.target_valid = 1'b1;
    end

    // static mode always divides; dynamic mode waits for every thread to pause
    st_next.lp_divide = st_reg.tilectl[TSC_DIV_EN_BIT] &&
                        (!st_reg.tilectl[TSC_DIV_DYN_BIT] ||
                         all_threads_paused);

    st_next.rg_clk = ctl.rgmii_clk;
    st_next.rg_launch = ctl.rgmii_launch;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else if (clock_en) begin
      st_reg <= st_next;
    end
  end

  // helper control wiring
  assign ctl.rgmii_divider = st_reg.tilectl[TSC_RG_DIV_LSB +: 9];
  assign ctl.rgmii_delay = st_reg.tilectl[TSC_RG_DLY_LSB +: 8];
  assign ctl.rgmii_enable = st_reg.tilectl[TSC_RG_EN_BIT];
  // core oscillators are counters 0 and 1, peripheral ones 2 and 3
  assign ctl.osc_run = {{2{st_reg.oscctl[TSC_OSC_PERI_BIT]}},
                        {2{st_reg.oscctl[TSC_OSC_CORE_BIT]}}};

  tsc_rgmii_clkgen u_rgmii (
    .clock    (clock),
    .reset_n  (reset_n),
    .clock_en (clock_en),
    .ctl      (ctl.rgmii)
  );

  // edges are taken as already aligned to clock; no synchroniser stands in front of the counters
  tsc_osc_counters #(
    .NUM   (OSC_NUM),
    .WIDTH (OSC_WIDTH)
  ) u_osc (
    .clock    (clock),
    .clock_en (clock_en),
    .osc_edge (osc_edge),
    .ctl      (ctl.osc)
  );

  // outputs
  assign ps_rdata = st_reg.rdata;
  assign ps_rvalid = st_reg.rvalid;
  assign event_target = st_reg.target;
  assign event_target_valid = st_reg.target_valid;
  assign rgmii_enable = st_reg.tilectl[TSC_RG_EN_BIT];
  assign rgmii_tx_clk = st_reg.rg_clk;
  assign rgmii_tx_launch = st_reg.rg_launch;
  assign low_power_divide = st_reg.lp_divide;
  assign usb_utmi_select = st_reg.tilectl[TSC_USB_MODE_BIT];
  assign ulpi_enable = st_reg.tilectl[TSC_ULPI_EN_BIT];
  assign global_debug_disable = st_reg.secure[TSC_SEC_GDBG_BIT];
  assign jtag_tap_disable = st_reg.secure[TSC_SEC_JTAG_BIT];
  assign otp_master_lock = st_reg.secure[TSC_SEC_MLOCK_BIT];
  assign otp_sector_lock = st_reg.secure[TSC_SEC_SLOCK_LSB +: 4];
  assign otp_redundancy_enable = st_reg.secure[TSC_SEC_REDUN_BIT];
  assign secure_boot_override = st_reg.secure[TSC_SEC_SBOOT_BIT];
  assign jtag_config_disable = st_reg.secure[TSC_SEC_PLLJ_BIT];
endmodule : tsc_status_regs

// >>> tsc_status_regs_props.sv
/*
  Port-level concurrent checks for the tile status configuration bank.
  Assumes one core clock and the bank's active-low asynchronous reset.
*/
`timescale 1ns/10ps
module tsc_status_regs_props (
  // clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        clock_en,
  // status access
  input wire logic        ps_write,
  input wire logic        ps_read,
  input wire logic [15:0] ps_resource_id,
  input wire logic [31:0] ps_wdata,
  input wire logic [31:0] ps_rdata,
  input wire logic        ps_rvalid,
  // events
  input wire logic        event_take,
  input wire logic [15:0] event_vector,
  input wire logic [31:0] event_target,
  input wire logic        event_target_valid,
  // security and feature controls
  input wire logic        otp_security_load,
  input wire logic [31:0] otp_security_word,
  input wire logic        rgmii_enable,
  input wire logic        usb_utmi_select,
  input wire logic        ulpi_enable,
  input wire logic        global_debug_disable,
  input wire logic        jtag_tap_disable,
  input wire logic        otp_master_lock,
  input wire logic [3:0]  otp_sector_lock,
  input wire logic        otp_redundancy_enable,
  input wire logic        secure_boot_override,
  input wire logic        jtag_config_disable
);
  logic        rd;
  logic        wr;
  logic [9:0]  sec_bits;
  logic        sec_lock_reg;

  assign rd = ps_read && clock_en;
  assign wr = ps_write && clock_en;
  assign sec_bits = {global_debug_disable, jtag_tap_disable, otp_master_lock, otp_sector_lock,
                     otp_redundancy_enable, secure_boot_override, jtag_config_disable};

  function automatic logic [9:0] sec_of(input logic [31:0] w);
    return {w[14], w[0], w[12], w[11:8], w[7], w[5], w[4]};
  endfunction : sec_of

  // shadow of the write-disable bit, which drives no control output and shows only in ps_rdata on a read
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) sec_lock_reg <= 1'b0;
    else if (clock_en && otp_security_load) sec_lock_reg <= otp_security_word[31];
    else if (wr && ps_resource_id == 16'h050B && !sec_lock_reg) sec_lock_reg <= ps_wdata[31];
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  read_answer_a: assert property (rd |=> ps_rvalid)
    else $error("read not answered next cycle");
  event_target_a: assert property (event_take && clock_en |=> event_target_valid &&
    event_target[15:0] == $past(event_vector) && event_target[17:16] == 2'b00)
    else $error("event target low half wrong");
  vector_event_a: assert property (wr && ps_resource_id == 16'h010B ##1
    (event_take && clock_en && !wr) |=> event_target[31:18] == $past(ps_wdata[31:18], 2))
    else $error("event target high half not from vector base");
  tile_write_a: assert property (wr && ps_resource_id == 16'h020B |=>
    {rgmii_enable, usb_utmi_select, ulpi_enable} == {$past(ps_wdata[8]), $past(ps_wdata[2:1])})
    else $error("tile control outputs do not follow write");
  sec_write_a: assert property (wr && ps_resource_id == 16'h050B && !sec_lock_reg &&
    !otp_security_load |=> sec_bits == sec_of($past(ps_wdata)))
    else $error("security outputs do not follow write");
  sec_hold_a: assert property (wr && ps_resource_id == 16'h050B && sec_lock_reg &&
    !otp_security_load |=> $stable(sec_bits))
    else $error("locked security word changed");
  sec_load_a: assert property (clock_en && otp_security_load |=>
    sec_bits == sec_of($past(otp_security_word)))
    else $error("security load not copied");
  boot_reserved_a: assert property (rd && ps_resource_id == 16'h030B |=>
    ps_rdata[31:24] == 8'h00 && ps_rdata[15:9] == 7'h00 && ps_rdata[7:6] == 2'h0)
    else $error("boot status reserved bits set");
  osc_reserved_a: assert property (rd && ps_resource_id == 16'h060B |=>
    ps_rdata[31:2] == 30'h0)
    else $error("oscillator control reserved bits set");
  unmapped_zero_a: assert property (rd && ps_resource_id[7:0] != 8'h0B |=>
    ps_rdata == 32'h0)
    else $error("unmapped read not zero");

  cover property (wr && ps_resource_id == 16'h050B && sec_lock_reg);
  cover property (event_target_valid);
  cover property (rd ##1 rd);
endmodule : tsc_status_regs_props

bind tsc_status_regs tsc_status_regs_props u_props (
  .clock(clock), .reset_n(reset_n), .clock_en(clock_en), .ps_write(ps_write),
  .ps_read(ps_read), .ps_resource_id(ps_resource_id), .ps_wdata(ps_wdata),
  .ps_rdata(ps_rdata), .ps_rvalid(ps_rvalid), .event_take(event_take),
  .event_vector(event_vector), .event_target(event_target),
  .event_target_valid(event_target_valid), .otp_security_load(otp_security_load),
  .otp_security_word(otp_security_word), .rgmii_enable(rgmii_enable),
  .usb_utmi_select(usb_utmi_select), .ulpi_enable(ulpi_enable),
  .global_debug_disable(global_debug_disable), .jtag_tap_disable(jtag_tap_disable),
  .otp_master_lock(otp_master_lock), .otp_sector_lock(otp_sector_lock),
  .otp_redundancy_enable(otp_redundancy_enable), .secure_boot_override(secure_boot_override),
  .jtag_config_disable(jtag_config_disable));
